/* hdl/adc_cfg_cfg.svh */
`ifndef ADC_CFG_CFG_SVH
`define ADC_CFG_CFG_SVH
// Register addresses
`define A_CTRL 8'h00
`define A_SWING 8'h01
`define A_TUNE_A 8'h03
`define A_TUNE_B 8'h06
`define A_CHA 8'h25
`define A_FMT 8'h29
`define A_CHB 8'h2b
`define A_OFFS 8'h3d
`define A_UPAT_H 8'h3f
`define A_UPAT_L 8'h40
`define A_OIF 8'h41
`define A_CDLY 8'h42
`define A_DIG 8'h44
`define A_PWR 8'h45
`define A_TUNE_C 8'hba
`define A_PED_A 8'hbf
`define A_PED_B 8'hc1
`define A_SWEN 8'hf1
// Field positions
`define B_RESET 1
`define B_READOUT 0
`define B_SNR 1
`define B_OFFS 5
`define B_DIG 0
`define B_QSLEEP 7
`define B_CLKDBL 6
`define B_DATDBL 5
`define B_SHUT 2
`define B_TUNE3 3
// Reset value of every register
`define REG_RST 8'h00
// Fixed codes
`define TOG_HI 14'h2aaa
`define TOG_LO 14'h1555
`define GAIN_MAX 4'hc
// Timing
`define MCLK_MHZ 50
`define POWER_AND_DRIVE_CFG_WAKE_US 50
`define PDN_WAKE_US 100
`define POWER_AND_DRIVE_CFG_WAKE_CYC (`POWER_AND_DRIVE_CFG_WAKE_US * `MCLK_MHZ)
`define PDN_WAKE_CYC_DEF (`PDN_WAKE_US * `MCLK_MHZ)
`endif

/* hdl/adc_cfg_pkg.sv */
`default_nettype none
package adc_cfg_pkg;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_POWER_AND_DRIVE_CFG = 2'b01,
    PWR_OFF = 2'b10,
    PWR_WAKE = 2'b11
  } pwr_e;
  typedef enum logic [2:0] {
    PAT_NORM = 3'b000,
    PAT_ZERO = 3'b001,
    PAT_ONES = 3'b010,
    PAT_TOG = 3'b011,
    PAT_RAMP = 3'b100,
    PAT_USER = 3'b101
  } pat_e;
  typedef struct packed {
    logic readout;
    logic [5:0] swing;
    logic snr_boost_bit;
    logic [1:0] tuning_pair;
    logic [3:0] chan_a_gain_step;
    logic [2:0] chan_a_pattern_sel;
    logic [1:0] fmt;
    logic [3:0] chan_b_gain_step;
    logic [2:0] chan_b_pattern_sel;
    logic offset_loop_on;
    logic [13:0] upat;
    logic [1:0] ifsel;
    logic [1:0] parallel_clock_drive;
    logic [1:0] output_buffer_off;
    logic [3:0] clock_output_delay_sel;
    logic dig_en;
    logic quick_sleep;
    logic clock_drive_double;
    logic data_drive_double;
    logic full_shutdown;
    logic tuning_bit_three;
    logic [5:0] chan_a_pedestal_value;
    logic [5:0] chan_b_pedestal_value;
    logic [1:0] swing_en;
  } regs_s;
  typedef struct packed {
    regs_s r;
    pwr_e pwr;
    logic [12:0] wake_cnt;
    logic sclk;
    logic [4:0] bit_cnt;
    logic [14:0] sh;
    logic [7:0] rd_sh;
    logic tog;
    logic [13:0] ramp;
    logic [13:0] dat_a;
    logic [13:0] dat_b;
  } state_s;
  typedef struct packed {
    logic [13:0] a;
    logic [13:0] b;
    logic valid;
  } smp_s;
  typedef struct packed {
    logic [13:0] a;
    logic [13:0] b;
  } dout_s;
  typedef struct packed {
    logic [5:0] swing;
    logic par_mode;
    logic [1:0] par_clk_drive;
    logic [3:0] clk_delay;
    logic clk_double;
    logic data_double;
    logic [3:0] gain_a;
    logic [3:0] gain_b;
    logic snr_boost;
    logic [2:0] tuning;
    logic offs_on;
    logic [5:0] ped_a;
    logic [5:0] ped_b;
  } acfg_s;
endpackage
`default_nettype wire

/* hdl/adc_cfg_bank.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg_cfg.svh"
module adc_cfg_bank #(
  parameter int PDN_WAKE_CYC = `PDN_WAKE_CYC_DEF
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Serial configuration port
  input wire logic CFG_SEN_N,
  input wire logic CFG_SCLK,
  input wire logic CFG_SDI,
  output logic CFG_SDO_O,
  output logic CFG_SDO_OE,
  // Converter samples
  input wire adc_cfg_pkg::smp_s SMP,
  // Output words and buffer enables
  output adc_cfg_pkg::dout_s DOUT,
  output logic DATA_A_OE,
  output logic DATA_B_OE,
  output logic CLK_OE,
  // Analog and pad settings
  output adc_cfg_pkg::acfg_s ACFG,
  // Power state
  output logic CORE_ON,
  output logic REF_ON,
  output logic CORE_READY
);
  import adc_cfg_pkg::*;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  function automatic logic [2:0] pat_fix(input logic [2:0] p);
    pat_fix = (p > 3'h5) ? 3'h0 : p;
  endfunction

  function automatic logic [3:0] gain_fix(input logic [3:0] g);
    gain_fix = (g > `GAIN_MAX) ? 4'h0 : g;
  endfunction

  function automatic logic [5:0] swing_fix(input logic [5:0] s);
    unique case (s)
      6'h00, 6'h1b, 6'h32, 6'h14, 6'h3e, 6'h0f: swing_fix = s;
      default: swing_fix = 6'h00;
    endcase
  endfunction

  function automatic logic [3:0] dly_fix(input logic [3:0] d);
    unique case (d)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'hb, 4'hf: dly_fix = d;
      default: dly_fix = 4'h0;
    endcase
  endfunction

  // ----------------------------------------
  // Register write and readback
  // ----------------------------------------
  // Only defined fields are stored, so reserved bits read zero
  function automatic regs_s reg_wr(input regs_s r, input logic [7:0] a,
                                   input logic [7:0] d);
    reg_wr = r;
    unique case (a)
      `A_CTRL: begin
        if (d[`B_RESET]) begin
          reg_wr = '0;
        end
        reg_wr.readout = d[`B_READOUT];
      end
      `A_SWING: reg_wr.swing = d[7:2];
      `A_TUNE_A: reg_wr.snr_boost_bit = d[`B_SNR];
      `A_TUNE_B: reg_wr.tuning_pair = d[2:1];
      `A_CHA: begin
        reg_wr.chan_a_gain_step = d[7:4];
        reg_wr.chan_a_pattern_sel = d[2:0];
      end
      `A_FMT: reg_wr.fmt = d[4:3];
      `A_CHB: begin
        reg_wr.chan_b_gain_step = d[7:4];
        reg_wr.chan_b_pattern_sel = d[2:0];
      end
      `A_OFFS: reg_wr.offset_loop_on = d[`B_OFFS];
      `A_UPAT_H: reg_wr.upat[13:8] = d[5:0];
      `A_UPAT_L: reg_wr.upat[7:0] = d;
      `A_OIF: begin
        reg_wr.ifsel = d[7:6];
        reg_wr.parallel_clock_drive = d[5:4];
        reg_wr.output_buffer_off = d[1:0];
      end
      `A_CDLY: reg_wr.clock_output_delay_sel = d[7:4];
      `A_DIG: reg_wr.dig_en = d[`B_DIG];
      `A_PWR: begin
        reg_wr.quick_sleep = d[`B_QSLEEP];
        reg_wr.clock_drive_double = d[`B_CLKDBL];
        reg_wr.data_drive_double = d[`B_DATDBL];
        reg_wr.full_shutdown = d[`B_SHUT];
      end
      `A_TUNE_C: reg_wr.tuning_bit_three = d[`B_TUNE3];
      `A_PED_A: reg_wr.chan_a_pedestal_value = d[7:2];
      `A_PED_B: reg_wr.chan_b_pedestal_value = d[7:2];
      `A_SWEN: reg_wr.swing_en = d[1:0];
      default: reg_wr = r;
    endcase
  endfunction

  function automatic logic [7:0] reg_rd(input regs_s r, input logic [7:0] a);
    unique case (a)
      `A_SWING: reg_rd = {r.swing, 2'h0};
      `A_TUNE_A: reg_rd = {6'h00, r.snr_boost_bit, 1'b0};
      `A_TUNE_B: reg_rd = {5'h00, r.tuning_pair, 1'b0};
      `A_CHA: reg_rd = {r.chan_a_gain_step, 1'b0, r.chan_a_pattern_sel};
      `A_FMT: reg_rd = {3'h0, r.fmt, 3'h0};
      `A_CHB: reg_rd = {r.chan_b_gain_step, 1'b0, r.chan_b_pattern_sel};
      `A_OFFS: reg_rd = {2'h0, r.offset_loop_on, 5'h00};
      `A_UPAT_H: reg_rd = {2'h0, r.upat[13:8]};
      `A_UPAT_L: reg_rd = r.upat[7:0];
      `A_OIF: reg_rd = {r.ifsel, r.parallel_clock_drive, 2'h0,
                        r.output_buffer_off};
      `A_CDLY: reg_rd = {r.clock_output_delay_sel, 4'h0};
      `A_DIG: reg_rd = {7'h00, r.dig_en};
      `A_PWR: reg_rd = {r.quick_sleep, r.clock_drive_double,
                        r.data_drive_double, 2'h0, r.full_shutdown, 2'h0};
      `A_TUNE_C: reg_rd = {4'h0, r.tuning_bit_three, 3'h0};
      `A_PED_A: reg_rd = {r.chan_a_pedestal_value, 2'h0};
      `A_PED_B: reg_rd = {r.chan_b_pedestal_value, 2'h0};
      `A_SWEN: reg_rd = {6'h00, r.swing_en};
      // Control register holds reset and readout, so it reads zero
      default: reg_rd = `REG_RST;
    endcase
  endfunction

  // Test pattern source for one channel, digital enable gates the pattern select but not the offset binary flip
  function automatic logic [13:0] chan_out(input logic [2:0] sel,
                                           input logic [13:0] smp,
                                           input regs_s r,
                                           input logic tog,
                                           input logic [13:0] ramp);
    unique case (sel)
      PAT_ZERO: chan_out = 14'h0000;
      PAT_ONES: chan_out = 14'h3fff;
      PAT_TOG: chan_out = tog ? `TOG_LO : `TOG_HI;
      PAT_RAMP: chan_out = ramp;
      PAT_USER: chan_out = r.upat;
      // Core delivers twos complement; flip sign for offset binary
      default: chan_out = (r.fmt == 2'b11) ? {~smp[13], smp[12:0]} : smp;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_s s_q;
  state_s s_d;
  logic sclk_rise;
  logic [7:0] rx_byte;
  logic [2:0] sel_a;
  logic [2:0] sel_b;
  logic dig_on;

  assign sclk_rise = CFG_SCLK & ~s_q.sclk;
  assign rx_byte = {s_q.sh[6:0], CFG_SDI};
  assign dig_on = s_q.r.dig_en;
  assign sel_a = dig_on ? pat_fix(s_q.r.chan_a_pattern_sel) : 3'h0;
  assign sel_b = dig_on ? pat_fix(s_q.r.chan_b_pattern_sel) : 3'h0;

  always_comb begin
    s_d = s_q;
    s_d.sclk = CFG_SCLK;
    // Serial frame: 8 address bits then 8 data bits, MSB first
    if (CFG_SEN_N) begin
      s_d.bit_cnt = 5'h00;
    end else if (sclk_rise && s_q.bit_cnt != 5'h10) begin
      s_d.sh = {s_q.sh[13:0], CFG_SDI};
      s_d.bit_cnt = s_q.bit_cnt + 5'h01;
      if (s_q.bit_cnt == 5'h07) begin
        s_d.rd_sh = reg_rd(s_q.r, rx_byte);
      end else begin
        s_d.rd_sh = {s_q.rd_sh[6:0], 1'b0};
      end
      // Readout mode blocks writes except to the control register
      if (s_q.bit_cnt == 5'h0f &&
          (!s_q.r.readout || s_q.sh[14:7] == `A_CTRL)) begin
        s_d.r = reg_wr(s_q.r, s_q.sh[14:7], rx_byte);
      end
    end
    // Power sequencing
    unique case (s_q.pwr)
      PWR_RUN: begin
        if (s_q.r.full_shutdown) begin
          s_d.pwr = PWR_OFF;
        end else if (s_q.r.quick_sleep) begin
          s_d.pwr = PWR_POWER_AND_DRIVE_CFG;
        end
      end
      PWR_POWER_AND_DRIVE_CFG: begin
        if (s_q.r.full_shutdown) begin
          s_d.pwr = PWR_OFF;
        end else if (!s_q.r.quick_sleep) begin
          s_d.pwr = PWR_WAKE;
          s_d.wake_cnt = 13'(`POWER_AND_DRIVE_CFG_WAKE_CYC);
        end
      end
      PWR_OFF: begin
        if (!s_q.r.full_shutdown) begin
          s_d.pwr = PWR_WAKE;
          s_d.wake_cnt = 13'(PDN_WAKE_CYC);
        end
      end
      PWR_WAKE: begin
        if (s_q.r.full_shutdown) begin
          s_d.pwr = PWR_OFF;
        end else if (s_q.r.quick_sleep) begin
          s_d.pwr = PWR_POWER_AND_DRIVE_CFG;
        end else if (s_q.wake_cnt <= 13'h0001) begin
          s_d.pwr = PWR_RUN;
        end else begin
          s_d.wake_cnt = s_q.wake_cnt - 13'h0001;
        end
      end
    endcase
    // Sample path advances once per converter sample
    if (SMP.valid) begin
      s_d.tog = ~s_q.tog;
      s_d.ramp = s_q.ramp + 14'h0001;
      s_d.dat_a = chan_out(sel_a, SMP.a, s_q.r, s_q.tog, s_q.ramp);
      s_d.dat_b = chan_out(sel_b, SMP.b, s_q.r, s_q.tog, s_q.ramp);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign CFG_SDO_O = s_q.rd_sh[7];
  assign CFG_SDO_OE = s_q.r.readout & ~CFG_SEN_N;
  assign DOUT.a = s_q.dat_a;
  assign DOUT.b = s_q.dat_b;
  // Shutdown also floats both data buses and the clock pad, whatever the buffer field says
  assign DATA_A_OE = ~s_q.r.output_buffer_off[1] & ~s_q.r.full_shutdown;
  assign DATA_B_OE = ~s_q.r.output_buffer_off[0] & ~s_q.r.full_shutdown;
  assign CLK_OE = (s_q.r.output_buffer_off != 2'b11) & ~s_q.r.full_shutdown;
  assign CORE_ON = (s_q.pwr == PWR_RUN) || (s_q.pwr == PWR_WAKE);
  assign REF_ON = (s_q.pwr != PWR_OFF);
  assign CORE_READY = (s_q.pwr == PWR_RUN);
  // Swing code is ignored until the override enable reads 11
  assign ACFG.swing = (s_q.r.swing_en == 2'b11) ? swing_fix(s_q.r.swing) : 6'h00;
  assign ACFG.par_mode = (s_q.r.ifsel == 2'b11);
  assign ACFG.par_clk_drive = s_q.r.parallel_clock_drive;
  assign ACFG.clk_delay = dly_fix(s_q.r.clock_output_delay_sel);
  assign ACFG.clk_double = s_q.r.clock_drive_double;
  assign ACFG.data_double = s_q.r.data_drive_double;
  assign ACFG.gain_a = gain_fix(s_q.r.chan_a_gain_step);
  assign ACFG.gain_b = gain_fix(s_q.r.chan_b_gain_step);
  assign ACFG.snr_boost = s_q.r.snr_boost_bit;
  assign ACFG.tuning = {s_q.r.tuning_bit_three, s_q.r.tuning_pair};
  assign ACFG.offs_on = s_q.r.offset_loop_on & dig_on;
  assign ACFG.ped_a = s_q.r.chan_a_pedestal_value;
  assign ACFG.ped_b = s_q.r.chan_b_pedestal_value;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  toggle_word_a: assert property ((sel_a == PAT_TOG && SMP.valid) |=>
    (DOUT.a == `TOG_HI || DOUT.a == `TOG_LO)) else $error("toggle word bad");
  toggle_alt_a: assert property ((sel_a == PAT_TOG && SMP.valid)[*2] |=>
    DOUT.a != $past(DOUT.a)) else $error("toggle did not alternate");
  user_word_a: assert property ((sel_b == PAT_USER && SMP.valid) |=>
    DOUT.b == $past(s_q.r.upat)) else $error("user pattern wrong");
  offs_bin_a: assert property ((sel_a == PAT_NORM && SMP.valid &&
    s_q.r.fmt == 2'b11) |=> DOUT.a == {~$past(SMP.a[13]), $past(SMP.a[12:0])})
    else $error("offset binary wrong");
  dig_gate_a: assert property ((!dig_on && SMP.valid && s_q.r.fmt != 2'b11)
    |=> DOUT.a == $past(SMP.a)) else $error("pattern without enable");
  buf_off_a: assert property (s_q.r.output_buffer_off == 2'b11 |->
    !CLK_OE && !DATA_A_OE && !DATA_B_OE) else $error("buffers not off");
  swing_gate_a: assert property (s_q.r.swing_en != 2'b11 |->
    ACFG.swing == 6'h00) else $error("swing applied without enable");
  gain_fix_a: assert property (s_q.r.chan_a_gain_step > `GAIN_MAX |->
    ACFG.gain_a == 4'h0) else $error("forbidden gain passed");
  wake_hold_a: assert property ((s_q.pwr == PWR_POWER_AND_DRIVE_CFG && !s_q.r.quick_sleep &&
    !s_q.r.full_shutdown) |=> (!CORE_READY && CORE_ON)[*8])
    else $error("standby wake too quick");
  shut_ref_a: assert property (s_q.r.full_shutdown |=> !REF_ON && !CORE_ON)
    else $error("shutdown ignored");
  iface_sel_a: assert property (ACFG.par_mode == (s_q.r.ifsel == 2'b11))
    else $error("interface select wrong");
  // Reset itself must be seen, so this one is never disabled
  reg_rst_a: assert property (disable iff (1'b0) !RST_N |=> s_q.r == '0)
    else $error("registers not cleared");

  // ----------------------------------------
  // Pattern checks
  // ----------------------------------------
  zero_word_a: assert property ((sel_a == PAT_ZERO && SMP.valid) |=>
    DOUT.a == 14'h0000)
    else $error("zeros pattern wrong");
  ones_word_a: assert property ((sel_a == PAT_ONES && SMP.valid) |=>
    DOUT.a == 14'h3fff)
    else $error("ones pattern wrong");
  // Ramp counter must already have moved past the word just sent
  ramp_step_a: assert property ((sel_a == PAT_RAMP && SMP.valid) |=>
    s_q.ramp == DOUT.a + 14'h0001)
    else $error("ramp did not step");
  pat_fix_a: assert property ((dig_on && s_q.r.chan_a_pattern_sel > 3'h5) |->
    sel_a == PAT_NORM)
    else $error("unused pattern code passed");
  fmt_twos_a: assert property ((sel_b == PAT_NORM && SMP.valid &&
    s_q.r.fmt != 2'b11) |=> DOUT.b == $past(SMP.b))
    else $error("twos complement wrong");
  offs_gate_a: assert property (!dig_on |->
    !ACFG.offs_on)
    else $error("offset loop without enable");

  // ----------------------------------------
  // Pad checks
  // ----------------------------------------
  swing_code_a: assert property (ACFG.swing inside {6'h00, 6'h1b, 6'h32,
    6'h14, 6'h3e, 6'h0f})
    else $error("unlisted swing code driven");
  delay_code_a: assert property (ACFG.clk_delay inside {4'h0, 4'h1, 4'h2,
    4'h3, 4'h7, 4'hb, 4'hf})
    else $error("unlisted delay code driven");
  gain_range_a: assert property (ACFG.gain_a <= `GAIN_MAX &&
    ACFG.gain_b <= `GAIN_MAX)
    else $error("gain above six dB");
  buf_b_off_a: assert property ((s_q.r.output_buffer_off == 2'b01 &&
    !s_q.r.full_shutdown) |-> !DATA_B_OE && DATA_A_OE && CLK_OE)
    else $error("channel B buffer not off");
  buf_a_off_a: assert property ((s_q.r.output_buffer_off == 2'b10 &&
    !s_q.r.full_shutdown) |-> !DATA_A_OE && DATA_B_OE && CLK_OE)
    else $error("channel A buffer not off");
  shut_pads_a: assert property (s_q.r.full_shutdown |->
    !DATA_A_OE && !DATA_B_OE && !CLK_OE)
    else $error("pads driven in shutdown");

  // ----------------------------------------
  // Power checks
  // ----------------------------------------
  power_and_drive_cfg_core_a: assert property (s_q.pwr == PWR_POWER_AND_DRIVE_CFG |->
    !CORE_ON && !CORE_READY && REF_ON)
    else $error("standby state wrong");
  sleep_enter_a: assert property ((s_q.pwr == PWR_RUN && s_q.r.quick_sleep &&
    !s_q.r.full_shutdown) |=> !CORE_ON && REF_ON)
    else $error("standby not entered");
  // No write can land inside eight cycles, so only a real early wake trips this
  pdn_wake_a: assert property ((s_q.pwr == PWR_OFF && !s_q.r.full_shutdown) |=>
    (!CORE_READY && REF_ON)[*8])
    else $error("shutdown wake too quick");
endmodule // adc_cfg_bank
`default_nettype wire

/* tb/adc_cfg_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg_cfg.svh"
module adc_cfg_host (
  // Clock
  input wire logic clk,
  // Serial lines
  output logic sen_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sen_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // ----------------------------------------
  // Writable bits of each register
  // ----------------------------------------
  function automatic logic [7:0] rsv_mask(input logic [7:0] a);
    case (a)
      `A_CTRL: return 8'h03;
      `A_SWING, `A_PED_A, `A_PED_B: return 8'hfc;
      `A_TUNE_A: return 8'h02;
      `A_TUNE_B: return 8'h06;
      `A_CHA, `A_CHB: return 8'hf7;
      `A_FMT: return 8'h18;
      `A_OFFS: return 8'h20;
      `A_UPAT_H: return 8'h3f;
      `A_OIF: return 8'hf3;
      `A_CDLY: return 8'hf0;
      `A_DIG: return 8'h01;
      `A_PWR: return 8'he4;
      `A_TUNE_C: return 8'h08;
      `A_SWEN: return 8'h03;
      default: return 8'hff;
    endcase
  endfunction
  // ----------------------------------------
  // One frame, MSB first
  // ----------------------------------------
  // Each SCLK level held two MCLK cycles so every rise is seen
  task automatic frame(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk) #1 sen_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sclk = 1'b0;
      sdi = w[15-i];
      if (i >= 8) begin
        rd[15-i] = sdo;
      end
      repeat (2) @(posedge clk);
      #1 sclk = 1'b1;
      repeat (2) @(posedge clk);
      #1;
    end
    sclk = 1'b0;
    repeat (2) @(posedge clk);
    #1 sen_n = 1'b1;
    // Idle data line keeps moving so a stale bit is never taken
    sdi = ~sdi;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] drop;
    frame({a, d & rsv_mask(a)}, drop);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    frame({a, 8'h00}, d);
  endtask
  task automatic set_swing(input logic [5:0] code);
    wr(`A_SWEN, 8'h03);
    wr(`A_SWING, {code, 2'b00});
  endtask
  task automatic best_tune();
    wr(`A_TUNE_B, 8'h06);
    wr(`A_TUNE_C, 8'h08);
  endtask
endmodule // adc_cfg_host
`default_nettype wire

/* tb/adc_output_config_bank_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adc_cfg_cfg.svh"
module adc_output_config_bank_tb;
  import adc_cfg_pkg::*;
  logic mclk, rst_n, sen_n, sclk, sdi, sdo, sdo_oe, sdo_line;
  logic oe_a, oe_b, oe_c, core_on, ref_on, core_ready;
  smp_s smp;
  dout_s dout;
  acfg_s acfg;
  int fails, cmp_count, cyc;
  logic [7:0] v;
  // ----------------------------------------
  // Clock, parts and timeout
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Short power-down wake keeps the run brief
  adc_cfg_bank #(.PDN_WAKE_CYC(20)) DUT (.MCLK(mclk), .RST_N(rst_n),
    .CFG_SEN_N(sen_n), .CFG_SCLK(sclk), .CFG_SDI(sdi), .CFG_SDO_O(sdo),
    .CFG_SDO_OE(sdo_oe), .SMP(smp), .DOUT(dout), .DATA_A_OE(oe_a),
    .DATA_B_OE(oe_b), .CLK_OE(oe_c), .ACFG(acfg), .CORE_ON(core_on),
    .REF_ON(ref_on), .CORE_READY(core_ready));
  // Released readback line shows the inverse, so a read outside the window fails
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  adc_cfg_host host (.clk(mclk), .sen_n(sen_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line));
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic sample(input logic [13:0] x, input logic [13:0] y);
    @(posedge mclk) #1 smp = '{a: x, b: y, valid: 1'b1};
    @(posedge mclk) #1 smp.valid = 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("acfg", acfg === '0, 1'b1);
    chk("dout", dout, 16'h0);
    chk("oe", {oe_a, oe_b, oe_c, core_ready, sdo_oe}, 5'h1e);
  endtask
  task automatic t_swing();
    logic [5:0] codes [7] = '{6'h00, 6'h1b, 6'h32, 6'h14, 6'h3e, 6'h0f, 6'h01};
    foreach (codes[i]) begin
      host.set_swing(codes[i]);
      chk("swing", acfg.swing, (i < 6) ? codes[i] : 6'h00);
    end
  endtask
  task automatic t_gain();
    for (int g = 0; g < 14; g++) begin
      host.wr(`A_CHA, {g[3:0], 4'h0});
      host.wr(`A_CHB, {g[3:0], 4'h0});
      chk("gain a", acfg.gain_a, (g <= 12) ? g : 0);
      chk("gain b", acfg.gain_b, (g <= 12) ? g : 0);
    end
  endtask
  task automatic t_tune();
    host.wr(`A_TUNE_A, 8'h02);
    chk("snr", acfg.snr_boost, 1'b1);
    host.best_tune();
    chk("tune", acfg.tuning, 3'b111);
  endtask
  task automatic t_iface();
    for (int i = 0; i < 4; i++) begin
      host.wr(`A_OIF, {i[1:0], i[1:0], 2'b00, i[1:0]});
      chk("par", acfg.par_mode, i == 3);
      chk("clk drv", acfg.par_clk_drive, i[1:0]);
      chk("buf oe", {oe_a, oe_b, oe_c}, {~i[1], ~i[0], i != 3});
    end
    host.wr(`A_OIF, 8'h00);
  endtask
  task automatic t_delay();
    for (int d = 0; d < 16; d++) begin
      host.wr(`A_CDLY, {d[3:0], 4'h0});
      chk("delay", acfg.clk_delay, (d inside {0, 1, 2, 3, 7, 11, 15}) ? d : 0);
    end
  endtask
  task automatic t_drive();
    host.wr(`A_PWR, 8'h40);
    chk("drv", {acfg.clk_double, acfg.data_double}, 2'b10);
    host.wr(`A_PWR, 8'h20);
    chk("drv", {acfg.clk_double, acfg.data_double}, 2'b01);
    host.wr(`A_PWR, 8'h00);
  endtask
  task automatic t_offset();
    host.wr(`A_OFFS, 8'h20);
    chk("offs gated", acfg.offs_on, 1'b0);
    host.wr(`A_DIG, 8'h01);
    chk("offs on", acfg.offs_on, 1'b1);
    host.wr(`A_PED_A, 8'h80);
    host.wr(`A_PED_B, 8'h7c);
    chk("ped", {acfg.ped_a, acfg.ped_b}, 12'h81f);
    host.wr(`A_OFFS, 8'h00);
    chk("offs off", acfg.offs_on, 1'b0);
  endtask
  task automatic t_format();
    for (int f = 0; f < 4; f++) begin
      host.wr(`A_FMT, {3'b000, f[1:0], 3'b000});
      sample(14'h0123, 14'h3ffe);
      chk("fmt a", dout.a, (f == 3) ? 14'h2123 : 14'h0123);
      chk("fmt b", dout.b, (f == 3) ? 14'h1ffe : 14'h3ffe);
    end
    host.wr(`A_FMT, 8'h00);
  endtask
  task automatic t_pattern();
    logic [13:0] r1;
    host.wr(`A_DIG, 8'h00);
    host.wr(`A_CHA, 8'h01);
    sample(14'h0155, 14'h0aaa);
    chk("pat gated", dout.a, 14'h0155);
    host.wr(`A_DIG, 8'h01);
    host.wr(`A_UPAT_H, 8'h15);
    host.wr(`A_UPAT_L, 8'hc3);
    host.wr(`A_CHB, 8'h05);
    sample(14'h0155, 14'h0aaa);
    chk("zeros", dout.a, 14'h0000);
    chk("user", dout.b, 14'h15c3);
    host.wr(`A_CHA, 8'h02);
    sample(14'h0155, 14'h0aaa);
    chk("ones", dout.a, 14'h3fff);
    host.wr(`A_CHA, 8'h03);
    sample(14'h0155, 14'h0aaa);
    r1 = dout.a;
    chk("tog", (r1 === `TOG_HI) || (r1 === `TOG_LO), 1'b1);
    sample(14'h0155, 14'h0aaa);
    chk("tog alt", dout.a, 14'(~r1));
    // Two samples back to back must still alternate
    @(posedge mclk) #1 smp.valid = 1'b1;
    repeat (2) @(posedge mclk);
    #1 smp.valid = 1'b0;
    chk("tog burst", dout.a, 14'(~r1));
    host.wr(`A_CHA, 8'h04);
    sample(14'h0155, 14'h0aaa);
    r1 = dout.a;
    sample(14'h0155, 14'h0aaa);
    chk("ramp", dout.a, 14'(r1 + 14'h1));
    host.wr(`A_CHA, 8'h06);
    sample(14'h0155, 14'h0aaa);
    chk("unused", dout.a, 14'h0155);
    host.wr(`A_CHA, 8'h00);
    host.wr(`A_CHB, 8'h00);
  endtask
  task automatic t_readout();
    host.wr(`A_CTRL, 8'h01);
    host.rd(`A_UPAT_H, v);
    chk("rd hi", v, 8'h15);
    host.rd(`A_UPAT_L, v);
    chk("rd lo", v, 8'hc3);
    host.rd(8'h02, v);
    chk("rd unmapped", v, 8'h00);
    host.wr(`A_CHA, 8'hc0);
    host.wr(`A_CTRL, 8'h00);
    chk("locked", {acfg.gain_a, sdo_oe}, 5'h00);
  endtask
  task automatic t_power();
    host.wr(`A_PWR, 8'h80);
    repeat (2) @(posedge mclk);
    #1 chk("power_and_drive_cfg", {core_on, core_ready, ref_on}, 3'b001);
    host.wr(`A_PWR, 8'h00);
    // Write lands three edges before return; ready comes 2501 cycles after that
    repeat (2497) @(posedge mclk);
    #1 chk("power_and_drive_cfg wake", {core_on, core_ready}, 2'b10);
    @(posedge mclk) #1 chk("power_and_drive_cfg up", core_ready, 1'b1);
    host.wr(`A_PWR, 8'h04);
    repeat (2) @(posedge mclk);
    #1 chk("pdn", {core_on, ref_on, oe_a, oe_b, oe_c}, 5'h00);
    host.wr(`A_PWR, 8'h00);
    chk("pdn wake", core_ready, 1'b0);
    // Shortened wake of 20 cycles set at the instance
    repeat (17) @(posedge mclk);
    #1 chk("pdn hold", core_ready, 1'b0);
    @(posedge mclk) #1 chk("pdn up", {core_ready, ref_on, oe_a}, 3'b111);
  endtask
  task automatic t_softreset();
    host.wr(`A_CHA, 8'hc0);
    chk("gain set", acfg.gain_a, 4'hc);
    host.wr(`A_CTRL, 8'h02);
    chk("soft rst", acfg === '0, 1'b1);
    host.wr(`A_CHA, 8'hc0);
    sample(14'h0155, 14'h0aaa);
    // Reset in mid-run clears registers and output words alike
    @(posedge mclk) #1 rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk("hard rst", acfg === '0, 1'b1);
    chk("hard dout", dout.a, 14'h0000);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    smp = '0;
    repeat (10) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_reset();
    t_swing();
    t_gain();
    t_tune();
    t_iface();
    t_delay();
    t_drive();
    t_offset();
    t_format();
    t_pattern();
    t_readout();
    t_power();
    t_softreset();
    report_and_stop();
  end
endmodule // adc_output_config_bank_tb
`default_nettype wire
